//--- logic/adram_params.svh
`ifndef ADRAM_PARAMS_SVH
`define ADRAM_PARAMS_SVH
// Clock period in ns
`define ADRAM_CLK_NS 40
// Strobe phase widths in ns
`define ADRAM_T_PRE_NS 120
`define ADRAM_T_RCD_NS 40
`define ADRAM_T_CAS_NS 160
`define ADRAM_T_REF_NS 200
// Refresh interval in ns, 2 ms over 128 rows
`define ADRAM_T_RFI_NS 15600
// Power-up wait in ns
`define ADRAM_T_PWR_NS 500000
// Dummy cycles after power-up
`define ADRAM_DUMMY_CNT 8
// Derived cycle counts, least times rounded up
`define ADRAM_CYC(ns) (((ns) + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
// Longest interval rounded down
`define ADRAM_RFI_CYC (`ADRAM_T_RFI_NS / `ADRAM_CLK_NS)
`define ADRAM_PWR_CYC `ADRAM_CYC(`ADRAM_T_PWR_NS)
`endif

//--- logic/adram_pkg.sv
package adram_pkg;
    // Request from the user side
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [3:0] wdata;
    } adram_req_type;
    // Pin group, strobes active low, plus the multiplexed address
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic ref_n;
        logic [7:0] addr;
    } adram_pins_type;
endpackage : adram_pkg

//--- logic/adram_ctrl.sv
`timescale 1ns/1ps
`include "adram_params.svh"
module adram_ctrl
    import adram_pkg::*;
#(
    parameter int unsigned PWR_CYC = `ADRAM_PWR_CYC,
    parameter int unsigned RFI_CYC = `ADRAM_RFI_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic REQ_VALID,
    input wire adram_req_type REQ,
    output logic REQ_READY,
    output logic RD_VALID,
    output logic [3:0] RD_DATA,
    output logic INIT_DONE,
    output adram_pins_type DRAM,
    output logic [3:0] DQ_OUT,
    output logic DQ_OE,
    input wire logic [3:0] DQ_IN
);
    localparam int unsigned PRE_CYC = `ADRAM_CYC(`ADRAM_T_PRE_NS);
    localparam int unsigned RCD_CYC = `ADRAM_CYC(`ADRAM_T_RCD_NS);
    localparam int unsigned CAS_CYC = `ADRAM_CYC(`ADRAM_T_CAS_NS);
    localparam int unsigned REF_CYC = `ADRAM_CYC(`ADRAM_T_REF_NS);
    // Power wait preload, so the wait starts straight from reset
    localparam logic [18:0] PWR_LOAD = 19'(PWR_CYC - 1);

    typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_ROW, ST_COL, ST_REF, ST_PRE} adram_state_type;

    // ****************************************
    // State and registers
    // ****************************************
    adram_state_type state_q, state_d;
    logic [18:0] cnt_q, cnt_d;
    logic [18:0] rfi_q;
    logic [3:0] dummy_q;
    logic ref_pend_q;
    logic write_q;
    logic [15:0] addr_q;
    logic [3:0] wdata_q;
    logic [3:0] dq_s1_q, dq_s2_q;
    adram_pins_type pins_q, pins_d;
    logic ready_q, rvalid_q, init_q, oe_q;
    logic [3:0] rdata_q;

    // Phase timeout helper
    function automatic logic [18:0] cyc(input int unsigned n);
        cyc = n[18:0] - 19'h00001;
    endfunction : cyc

    wire cnt_zero = (cnt_q == 19'h00000);
    wire take_req = (state_q == ST_IDLE) && !ref_pend_q && REQ_VALID && init_q;
    wire go_ref = (state_q == ST_IDLE) && (ref_pend_q || !init_q);
    wire rfi_hit = (rfi_q == 19'h00000);
    wire col_end = (state_q == ST_COL) && cnt_zero;
    wire ref_end = (state_q == ST_REF) && cnt_zero;
    wire pwr_end = (state_q == ST_PWR) && cnt_zero;
    wire dummy_last = (dummy_q == 4'h1);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_zero ? cnt_q : cnt_q - 19'h00001;
        pins_d = pins_q;
        case (state_q)
            ST_PWR: begin
                if (cnt_zero) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (go_ref) begin
                    // Automatic refresh with row strobe held high
                    pins_d.ref_n = 1'b0;
                    state_d = ST_REF;
                    cnt_d = cyc(REF_CYC);
                end else if (take_req) begin
                    pins_d.addr = REQ.addr[15:8];
                    pins_d.ras_n = 1'b0;
                    state_d = ST_ROW;
                    cnt_d = cyc(RCD_CYC);
                end
            end
            ST_ROW: begin
                if (cnt_zero) begin
                    pins_d.addr = addr_q[7:0];
                    pins_d.we_n = !write_q; // Early write
                    state_d = ST_COL;
                    // One extra cycle, the column strobe falls a cycle after entry
                    cnt_d = cyc(CAS_CYC + 1);
                end
            end
            ST_COL: begin
                pins_d.cas_n = 1'b0;
                if (cnt_zero) begin
                    pins_d.ras_n = 1'b1;
                    pins_d.cas_n = 1'b1; // No output hold used, released at once
                    pins_d.we_n = 1'b1;
                    state_d = ST_PRE;
                    cnt_d = cyc(PRE_CYC);
                end
            end
            ST_REF: begin
                if (cnt_zero) begin
                    pins_d.ref_n = 1'b1;
                    state_d = ST_PRE;
                    cnt_d = cyc(PRE_CYC);
                end
            end
            ST_PRE: begin
                if (cnt_zero) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Main registers
    // ****************************************
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_PWR;
            cnt_q <= PWR_LOAD;
            pins_q <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, addr: 8'h00};
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
        end
    end

    // Request capture and data drive
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            write_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 4'h0;
            oe_q <= 1'b0;
        end else begin
            if (take_req) begin
                write_q <= REQ.write;
                addr_q <= REQ.addr;
                wdata_q <= REQ.wdata;
            end
            oe_q <= take_req ? REQ.write : (col_end ? 1'b0 : oe_q);
        end
    end

    // ****************************************
    // Refresh interval and power-up dummies
    // ****************************************
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rfi_q <= 19'h00000;
            ref_pend_q <= 1'b0;
            dummy_q <= 4'h0;
            init_q <= 1'b0;
        end else begin
            rfi_q <= rfi_hit ? cyc(RFI_CYC) : rfi_q - 19'h00001;
            ref_pend_q <= (rfi_hit && init_q) || (ref_pend_q && !go_ref);
            if (pwr_end) begin
                dummy_q <= 4'(`ADRAM_DUMMY_CNT);
            end else if (ref_end && !init_q && dummy_q != 4'h0) begin
                dummy_q <= dummy_q - 4'h1;
                init_q <= dummy_last;
            end
        end
    end

    // ****************************************
    // Read data return
    // ****************************************
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dq_s1_q <= 4'h0;
            dq_s2_q <= 4'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 4'h0;
            ready_q <= 1'b0;
        end else begin
            dq_s1_q <= DQ_IN;
            dq_s2_q <= dq_s1_q;
            rvalid_q <= col_end && !write_q;
            if (col_end && !write_q) begin
                rdata_q <= dq_s2_q;
            end
            ready_q <= (state_d == ST_IDLE) && init_q && !ref_pend_q && !(rfi_hit && init_q) && !take_req;
        end
    end

    assign REQ_READY = ready_q;
    assign RD_VALID = rvalid_q;
    assign RD_DATA = rdata_q;
    assign INIT_DONE = init_q;
    assign DRAM = pins_q;
    assign DQ_OUT = wdata_q;
    assign DQ_OE = oe_q;
endmodule : adram_ctrl

//--- bench/adram_dram_model.sv
`timescale 1ns/1ps
module adram_dram_model (
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic ref_n,
    input wire logic [7:0] addr,
    input wire logic [3:0] d,
    output logic [3:0] q
);
    logic [3:0] mem [0:65535];
    logic [7:0] row_q = 8'h0;
    logic [15:0] sel_q = 16'h0;
    logic early_q = 1'b0;
    logic [6:0] ref_cnt_q = 7'h0;
    // Address capture and write strobing
    always @(negedge ras_n) row_q = addr;
    always @(negedge cas_n) begin
        sel_q = {row_q, addr};
        early_q = !we_n;
        if (!we_n) mem[sel_q] = d;
    end
    always @(negedge we_n) if (!cas_n) mem[sel_q] = d;
    // Automatic refresh row counter
    always @(posedge ref_n) if (ras_n) ref_cnt_q = ref_cnt_q + 7'h1;
    // Self refresh once the request stays low past one internal period
    always @(negedge ref_n) begin
        #12000;
        if (!ref_n && ras_n) ref_cnt_q = ref_cnt_q + 7'h1;
    end
    // Released outputs show the inverse of the cell
    assign q = (cas_n || early_q) ? ~mem[sel_q] : mem[sel_q];
endmodule : adram_dram_model

//--- bench/adram_ctrl_checker.sv
`timescale 1ns/1ps
module adram_ctrl_checker
    import adram_pkg::*;
#(
    parameter int unsigned RFI_CYC = 40
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic RD_VALID,
    input wire logic REQ_READY,
    input wire logic INIT_DONE,
    input wire adram_pins_type DRAM,
    input wire logic [3:0] DQ_OUT,
    input wire logic DQ_OE
);
    logic [15:0] gap_q;
    logic [3:0] dum_q;
    logic ref_q;
    // Cycles since last refresh and count of refresh starts
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gap_q <= 16'h0;
            dum_q <= 4'h0;
            ref_q <= 1'b1;
        end else begin
            gap_q <= (!DRAM.ref_n || !INIT_DONE) ? 16'h0 : gap_q + 16'h1;
            dum_q <= (ref_q && !DRAM.ref_n && dum_q != 4'hf) ? dum_q + 4'h1 : dum_q;
            ref_q <= DRAM.ref_n;
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_read_cas;
        $fell(DRAM.cas_n) && DRAM.we_n;
    endsequence
    a_ref_ras_apart: assert property (!(!DRAM.ras_n && !DRAM.ref_n))
        else $error("refresh overlaps row strobe");
    a_write_early_only: assert property ($fell(DRAM.we_n) |-> DRAM.cas_n)
        else $error("write strobe fell after column strobe");
    a_write_data_held: assert property (!DRAM.cas_n && !DRAM.we_n |-> DQ_OE && $stable(DQ_OUT))
        else $error("write data not held");
    a_row_then_col: assert property ($fell(DRAM.cas_n) |-> !DRAM.ras_n && !$past(DRAM.ras_n, 2))
        else $error("column strobe without row first");
    a_refresh_gap: assert property (gap_q <= RFI_CYC + 16)
        else $error("refresh interval too long");
    a_dummy_count: assert property ($rose(INIT_DONE) |-> dum_q == 4'h8)
        else $error("init without eight dummy cycles");
    a_no_early_ready: assert property (!INIT_DONE |-> !REQ_READY)
        else $error("ready before init");
    a_read_answer: assert property (s_read_cas |-> ##[2:10] RD_VALID)
        else $error("read gave no answer");
endmodule : adram_ctrl_checker
bind adram_ctrl adram_ctrl_checker #(.RFI_CYC(RFI_CYC)) i_adram_ctrl_checker (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .RD_VALID(RD_VALID), .REQ_READY(REQ_READY), .INIT_DONE(INIT_DONE), .DRAM(DRAM), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));

//--- bench/adram_ctrl_tb.sv
`timescale 1ns/1ps
module adram_ctrl_tb;
    import adram_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic REQ_VALID = 1'b0;
    adram_req_type REQ = '0;
    logic REQ_READY, RD_VALID, INIT_DONE, DQ_OE;
    logic [3:0] RD_DATA, DQ_OUT, DQ_IN;
    adram_pins_type DRAM;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [15:0] adr_tab [4] = '{16'h0000, 16'hffff, 16'h0102, 16'h0201};
    logic [3:0] dat_tab [4] = '{4'h5, 4'ha, 4'h1, 4'h8};
    // Clock and watchdog
    initial forever #20 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    adram_ctrl #(.PWR_CYC(4), .RFI_CYC(40)) i_adram_ctrl (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
        .REQ(REQ), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .INIT_DONE(INIT_DONE), .DRAM(DRAM),
        .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(DQ_IN));
    adram_dram_model i_adram_dram_model (.ras_n(DRAM.ras_n), .cas_n(DRAM.cas_n), .we_n(DRAM.we_n), .ref_n(DRAM.ref_n),
        .addr(DRAM.addr), .d(DQ_OUT), .q(DQ_IN));
    // Verdict and comparison helpers
    task automatic print_verdict;
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    // One request, held until the taking edge
    task automatic send(input logic wr, input logic [15:0] a, input logic [3:0] d);
        for (int n = 0; n < 99 && REQ_READY !== 1'b1; n++) @(negedge SYS_CLK);
        REQ_VALID = 1'b1;
        REQ = '{write: wr, addr: a, wdata: d};
        @(negedge SYS_CLK);
        REQ_VALID = 1'b0;
    endtask : send
    task automatic rd(input logic [15:0] a, input logic [3:0] exp);
        send(1'b0, a, 4'h0);
        for (int n = 0; n < 20 && RD_VALID !== 1'b1; n++) @(negedge SYS_CLK);
        chk(RD_VALID === 1'b1 && RD_DATA === exp, "read data wrong");
    endtask : rd
    // Scenarios
    task automatic sc_init;
        logic [6:0] base;
        base = i_adram_dram_model.ref_cnt_q;
        for (int n = 0; n < 400 && INIT_DONE !== 1'b1; n++) @(negedge SYS_CLK);
        chk(INIT_DONE === 1'b1 && 7'(i_adram_dram_model.ref_cnt_q - base) === 7'h8, "init sequence");
    endtask : sc_init
    task automatic sc_wr;
        foreach (adr_tab[i]) send(1'b1, adr_tab[i], dat_tab[i]);
        foreach (adr_tab[i]) rd(adr_tab[i], dat_tab[i]);
    endtask : sc_wr
    task automatic sc_ref;
        logic [6:0] base;
        base = i_adram_dram_model.ref_cnt_q;
        repeat (100) @(negedge SYS_CLK);
        chk(7'(i_adram_dram_model.ref_cnt_q - base) >= 7'h2, "refresh too rare");
        rd(16'h0102, 4'h1);
    endtask : sc_ref
    task automatic sc_rst;
        send(1'b1, 16'h0201, 4'h3);
        RESET_N = 1'b0;
        @(negedge SYS_CLK);
        chk(DRAM.ras_n === 1'b1 && DRAM.cas_n === 1'b1 && DQ_OE === 1'b0 && REQ_READY === 1'b0, "reset state");
        repeat (3) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        sc_init();
        rd(16'hffff, 4'ha);
        rd(16'h0201, 4'h8);
    endtask : sc_rst
    // Main sequence
    initial begin
        repeat (4) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        sc_init();
        sc_wr();
        sc_ref();
        sc_rst();
        print_verdict();
    end
endmodule : adram_ctrl_tb
